// ==== pkg/fbd_defines.vh ====
// Constants for the five-bit reference converter control block
`ifndef FBD_DEFINES_VH
`define FBD_DEFINES_VH
`define FBD_ADDR_W         4
`define FBD_OFF_CTRL       4'h0
`define FBD_OFF_LEVEL      4'h1
`define FBD_OFF_STATUS     4'h2
`define FBD_BIT_EN         7
`define FBD_BIT_ROUTE1     5
`define FBD_BIT_ROUTE2     4
`define FBD_PSS_HI         3
`define FBD_PSS_LO         2
`define FBD_NSS_HI         1
`define FBD_NSS_LO         0
`define FBD_CTRL_MASK      8'hBF
`define FBD_LEVEL_MASK     8'h1F
`define FBD_CTRL_RST       8'h00
`define FBD_LEVEL_RST      5'h00
`define FBD_LEVEL_BITS     5
`define FBD_LEVELS         32
`define FBD_PSS_SUPPLY     2'h0
`define FBD_PSS_REFPIN     2'h1
`define FBD_PSS_FIXED      2'h2
`define FBD_NSS_GROUND     2'h0
`define FBD_NSS_REF0       2'h1
`define FBD_NSS_REF1       2'h2
`endif

// ==== sim/fbd_dac_ctrl_assertions.sv ====
// Port checker for the converter control block
`timescale 1ns/1ns
module fbd_chk (
	input wire       core_clk, rstn, ce, wr, rd, ladder_enable,
	input wire [3:0] addr,
	input wire [7:0] wdata, rdata,
	input wire [4:0] ladder_tap,
	input wire [1:0] gpio_out, gpio_oe_n, pad_out, pad_oe_n, gpio_in,
	input wire [1:0] converter_output_pin,
	input wire [1:0] positive_source_select, negative_source_select
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_ctl; wr && ce && addr == 4'h0; endsequence
	sequence s_lvl; wr && ce && addr == 4'h1; endsequence
	AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	AST_EN: assert property (s_ctl |=> ##1 ladder_enable == $past(wdata[7], 2))
		else $error("enable not applied");
	AST_ROUTE: assert property (s_ctl |=> converter_output_pin ==
		{$past(wdata[4]), $past(wdata[5])}) else $error("route bits wrong");
	AST_TAP: assert property (s_lvl |=> ##1 ladder_tap == $past(wdata[4:0], 2))
		else $error("level code not applied");
	AST_PSS: assert property (s_ctl |=> ##1 positive_source_select ==
		(&$past(wdata[3:2], 2) ? 2'h0 : $past(wdata[3:2], 2)))
		else $error("positive select wrong");
	AST_NSS: assert property (s_ctl |=> ##1 negative_source_select ==
		(&$past(wdata[1:0], 2) ? 2'h0 : $past(wdata[1:0], 2)))
		else $error("negative select wrong");
	AST_PIN_OFF: assert property (!(|(converter_output_pin &
		(~pad_oe_n | pad_out | gpio_in)))) else $error("routed pin not isolated");
	AST_PASS: assert property (!(|(~converter_output_pin &
		(pad_out ^ gpio_out | pad_oe_n ^ gpio_oe_n)))) else $error("pin not passed");
	AST_RST: assert property (disable iff (1'b0) !rstn && ce |=>
		converter_output_pin == 2'h0 && !ladder_enable && ladder_tap == 5'h00)
		else $error("reset did not clear");
endmodule
bind fbd_dac_ctrl fbd_chk u_chk (.*);

// ==== sim/tb.sv ====
// Register-level bench for the converter control block
`timescale 1ns/1ns
module tb;
	reg        core_clk = 0, rstn = 0, ce = 1, wr = 0, rd = 0, sleep = 0;
	reg  [3:0] addr = 4'h0;
	reg  [7:0] wdata = 8'h00;
	reg  [1:0] gpio_out = 2'h2, gpio_oe_n = 2'h1, pad_in = 2'h3;
	wire [7:0] rdata;
	wire [1:0] pad_out, pad_oe_n, gpio_in, converter_output_pin;
	wire [1:0] positive_source_select, negative_source_select;
	wire       ladder_enable;
	wire [4:0] ladder_tap;
	integer    errors = 0, num_checks = 0, cyc = 0, i;
	fbd_dac_ctrl dut (.*);
	always #50 core_clk = ~core_clk;
	task chk(input [7:0] seen, input [7:0] exp, input string name);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[FAIL] %0s exp %h seen %h", name, exp, seen);
		end
	endtask
	task wr_reg(input [3:0] a, input [7:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
	endtask
	task rd_reg(input [3:0] a, input [7:0] e, input string name);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk(rdata, e, name);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Generous ceiling: the sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			end_sim;
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		rd_reg(4'h0, 8'h00, "ctrl rst");
		rd_reg(4'h1, 8'h00, "level rst");
		wr_reg(4'h0, 8'hFF);
		rd_reg(4'h0, 8'hBF, "ctrl");
		chk(pad_oe_n, 8'h03, "pad oe");
		chk(gpio_in, 8'h00, "pad read");
		wr_reg(4'h0, 8'hA0);
		chk(converter_output_pin, 8'h01, "route");
		chk(pad_out, 8'h02, "pass");
		chk(gpio_in, 8'h02, "pad read 2");
		for (i = 0; i < 32; i = i + 1) begin
			wr_reg(4'h1, {3'h7, i[4:0]});
			@(posedge core_clk);
			#1 chk(ladder_tap, i[7:0], "tap");
		end
		rd_reg(4'h1, 8'h1F, "level");
		for (i = 0; i < 4; i = i + 1) begin
			wr_reg(4'h0, {4'h8, i[1:0], i[1:0]});
			@(posedge core_clk);
			#1 chk(positive_source_select, i == 3 ? 8'h00 : i[7:0], "pss");
			chk(negative_source_select, i == 3 ? 8'h00 : i[7:0], "nss");
		end
		rd_reg(4'h0, 8'h8F, "ctrl rsv");
		rd_reg(4'hF, 8'h00, "unmapped");
		@(posedge core_clk);
		sleep <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1 chk(ladder_enable, 8'h01, "sleep run");
		rd_reg(4'h2, 8'h03, "status sleep");
		@(posedge core_clk);
		sleep <= 1'b0;
		rd_reg(4'h0, 8'h8F, "wake");
		wr_reg(4'h0, 8'h30);
		@(posedge core_clk);
		#1 chk(ladder_enable, 8'h00, "off");
		// Software turns the ladder off before Sleep to save current
		@(posedge core_clk);
		sleep <= 1'b1;
		rd_reg(4'h2, 8'h32, "status off");
		@(posedge core_clk);
		sleep <= 1'b0;
		wr_reg(4'h0, 8'hB0);
		@(posedge core_clk);
		#1 chk(ladder_enable, 8'h01, "on again");
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		#1 chk(converter_output_pin, 8'h00, "rst pin");
		chk(ladder_enable, 8'h00, "rst en");
		rd_reg(4'h1, 8'h00, "rst level");
		// Clock enable low must freeze the registers against writes
		@(posedge core_clk);
		ce <= 1'b0;
		wr_reg(4'h1, 8'h0A);
		@(posedge core_clk);
		ce <= 1'b1;
		rd_reg(4'h1, 8'h00, "ce frozen");
		wr_reg(4'h1, 8'h0A);
		rd_reg(4'h1, 8'h0A, "ce live");
		end_sim;
	end
endmodule

// ==== verilog/fbd_dac_ctrl.v ====
// Register file and analog control for one five-bit converter instance
`timescale 1ns/1ns
`include "fbd_defines.vh"
module fbd_dac_ctrl #(
	parameter HAS_REF1 = 1
) (
	input  wire                    core_clk,
	input  wire                    rstn,
	input  wire                    ce,
	input  wire [`FBD_ADDR_W-1:0]  addr,
	input  wire [7:0]              wdata,
	input  wire                    wr,
	input  wire                    rd,
	output reg  [7:0]              rdata,
	input  wire                    sleep,
	input  wire [1:0]              gpio_out,
	input  wire [1:0]              gpio_oe_n,
	input  wire [1:0]              pad_in,
	output wire [1:0]              pad_out,
	output wire [1:0]              pad_oe_n,
	output wire [1:0]              gpio_in,
	output wire [1:0]              converter_output_pin,
	output reg                     ladder_enable,
	output reg  [4:0]              ladder_tap,
	output reg  [1:0]              positive_source_select,
	output reg  [1:0]              negative_source_select
);
	////////////////////////////////////////////////////////////////////
	reg  [7:0] converter_control_reg;
	reg  [4:0] converter_level_reg;
	wire       wr_ctrl;
	wire       wr_level;
	wire [1:0] pin_route_enable;
	wire       pin_route_enable_first;
	wire       pin_route_enable_second;

	function [1:0] fbd_fix_sel;
		input [1:0] code;
		input       allow_two;
		begin
			// Reserved codes fall back to the default source
			if (code == 2'h3 || (code == 2'h2 && !allow_two))
				fbd_fix_sel = 2'h0;
			else
				fbd_fix_sel = code;
		end
	endfunction

	assign wr_ctrl  = wr && (addr == `FBD_OFF_CTRL);
	assign wr_level = wr && (addr == `FBD_OFF_LEVEL);

	////////////////////////////////////////////////////////////////////
	// Sleep deliberately feeds only the status readback in rdata: contents survive
	// wake-up and the ladder keeps running, at a current cost.
	always @(posedge core_clk) begin
		if (!rstn) begin
			converter_control_reg <= `FBD_CTRL_RST;
			converter_level_reg   <= `FBD_LEVEL_RST;
		end else if (ce) begin
			if (wr_ctrl)
				converter_control_reg <= wdata & `FBD_CTRL_MASK;
			if (wr_level)
				converter_level_reg <= wdata[`FBD_LEVEL_BITS-1:0];
		end
	end

	assign pin_route_enable_first  = converter_control_reg[`FBD_BIT_ROUTE1];
	assign pin_route_enable_second = converter_control_reg[`FBD_BIT_ROUTE2];
	assign pin_route_enable = {pin_route_enable_second,
		pin_route_enable_first};

	////////////////////////////////////////////////////////////////////
	// Analog controls registered so the ladder sees glitch-free codes
	always @(posedge core_clk) begin
		if (!rstn) begin
			ladder_enable          <= 1'b0;
			ladder_tap             <= 5'h00;
			positive_source_select <= `FBD_PSS_SUPPLY;
			negative_source_select <= `FBD_NSS_GROUND;
		end else if (ce) begin
			ladder_enable <= converter_control_reg[`FBD_BIT_EN];
			// Tap k of 32 gives span*k/32 above the negative source
			ladder_tap <= converter_level_reg;
			positive_source_select <= fbd_fix_sel(
				converter_control_reg[`FBD_PSS_HI:`FBD_PSS_LO],
				1'b1);
			negative_source_select <= fbd_fix_sel(
				converter_control_reg[`FBD_NSS_HI:`FBD_NSS_LO],
				HAS_REF1 != 0);
		end
	end

	////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
			fbd_pin_gate u_pin (
				.core_clk       (core_clk),
				.rstn           (rstn),
				.ce             (ce),
				.route_en       (pin_route_enable[gi]),
				.gpio_out       (gpio_out[gi]),
				.gpio_oe_n      (gpio_oe_n[gi]),
				.pad_in         (pad_in[gi]),
				.pad_out        (pad_out[gi]),
				.pad_oe_n       (pad_oe_n[gi]),
				.analog_connect (converter_output_pin[gi]),
				.gpio_in        (gpio_in[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
				`FBD_OFF_CTRL:   rdata <= converter_control_reg;
				`FBD_OFF_LEVEL:  rdata <= {3'h0, converter_level_reg};
				`FBD_OFF_STATUS: rdata <= {2'h0, converter_output_pin,
					2'h0, sleep, ladder_enable};
				default:         rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

// ==== verilog/fbd_pin_gate.v ====
// Pin override for one converter output pin
`timescale 1ns/1ns
module fbd_pin_gate (
	input  wire core_clk,
	input  wire rstn,
	input  wire ce,
	input  wire route_en,
	input  wire gpio_out,
	input  wire gpio_oe_n,
	input  wire pad_in,
	output wire pad_out,
	output wire pad_oe_n,
	output wire analog_connect,
	output wire gpio_in
);
	wire pad_sync;
	fbd_sync2 u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.din      (pad_in),
		.dout     (pad_sync)
	);
	// Routing kills the digital driver and the input detector
	assign analog_connect = route_en;
	assign pad_oe_n = route_en ? 1'b1 : gpio_oe_n;
	assign pad_out  = route_en ? 1'b0 : gpio_out;
	assign gpio_in  = route_en ? 1'b0 : pad_sync;
endmodule

// ==== verilog/fbd_sync2.v ====
// Two-flop synchroniser for a level arriving from a pin
`timescale 1ns/1ns
module fbd_sync2 (
	input  wire core_clk,
	input  wire rstn,
	input  wire ce,
	input  wire din,
	output wire dout
);
	reg meta_reg;
	reg sync_reg;
	always @(posedge core_clk) begin
		if (!rstn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else if (ce) begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end
	assign dout = sync_reg;
endmodule
